//--- design/scps_pkg.sv
package scps_pkg;

  // Register map and reset value
  localparam logic [15:0] SCPS_SEL_ADDR       = 16'hFF43;
  localparam logic [7:0]  SCPS_SEL_RESET      = 8'h88;
  localparam int          SCPS_CH0_LSB        = 0;
  localparam int          SCPS_CH1_LSB        = 4;
  localparam logic [3:0]  SCPS_CODE_MIN       = 4'h6;
  localparam logic [3:0]  SCPS_CODE_MAX       = 4'hD;
  localparam logic [3:0]  SCPS_BUS_EXP_OFFSET = 4'h1;
  localparam logic [3:0]  SCPS_SIO_EXP_OFFSET = 4'h5;
  localparam int          SCPS_CNT_W          = 14;
  localparam logic [13:0] SCPS_CNT_RESET      = 14'h0000;
  localparam logic [1:0]  SCPS_SRC_INTERNAL   = 2'h3;

  typedef enum logic [1:0]
  {
    SCPS_MODE_SIO3 = 2'b00,
    SCPS_MODE_SIO2 = 2'b01,
    SCPS_MODE_BUS  = 2'b10
  } scps_mode_t;

  typedef struct packed
  {
    logic        wr_en;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } scps_wr_t;

  typedef struct packed
  {
    logic ch0_tick;
    logic ch0_valid;
    logic ch1_tick;
    logic ch1_valid;
  } scps_clk_t;

endpackage

//--- design/scps_tick_gen.sv
`timescale 1ns/100ps
// One divider channel: strobe every 2**exp input ticks
module scps_tick_gen
  import scps_pkg::*;
(
  input  wire logic                  clk_sys_in,
  input  wire logic                  sys_rst_in,
  input  wire logic                  src_tick_in,
  input  wire logic [3:0]            exp_in,
  input  wire logic                  restart_in,
  output logic                       tick_out
);

  logic [SCPS_CNT_W-1:0] cnt_ff;
  logic                  tick_ff;
  logic [SCPS_CNT_W-1:0] mask;

  assign mask = SCPS_CNT_W'((15'h0001 << exp_in) - 15'h0001);

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || restart_in)
      cnt_ff <= SCPS_CNT_RESET;
    else if (src_tick_in)
      cnt_ff <= (cnt_ff + 14'h0001) & mask;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || restart_in)
      tick_ff <= 1'b0;
    else
      tick_ff <= src_tick_in && ((cnt_ff & mask) == mask);
  end

  assign tick_out = tick_ff;

endmodule // scps_tick_gen

//--- design/scps_top.sv
`timescale 1ns/100ps
// Functional notes
// - Reset loads the select register with 0x88.
// - Channel 0 bus mode codes 6..13 divide the main clock by 2**(n-1), others prohibited.
// - Channel 0 shift mode codes 6..13 divide the main clock by 2**(n-5).
// - Channel 1 codes 6..13 divide the main clock by 2**(n-5), others prohibited.
// - Divider input is the oscillator when the mode bit is 1, half of it when 0.
// - Channel 0 uses this clock only when both its clock-source bits are 1.
module scps_top
  import scps_pkg::*;
(
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        wr_en_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        main_clk_full_rate_in,
  input  wire logic [1:0]  ch0_mode_sel_in,
  input  wire logic        ch0_clk_src_b1_in,
  input  wire logic        ch0_clk_src_b0_in,
  output logic      [7:0]  rdata_out,
  output logic             ch0_tick_out,
  output logic             ch0_valid_out,
  output logic             ch1_tick_out,
  output logic             ch1_valid_out
);

  scps_wr_t   wr;
  scps_clk_t  clk_o;
  scps_mode_t mode;
  logic [7:0] serial_clock_prescale_select_ff;
  logic [7:0] nxt_serial_clock_prescale_select;
  logic       half_ff;
  logic       src_tick;
  logic       sel_write;
  logic [3:0] ch0_code;
  logic [3:0] ch1_code;
  logic [3:0] ch0_exp;
  logic [3:0] ch1_exp;
  logic       ch0_code_ok;
  logic       ch1_code_ok;
  logic       ch0_internal;
  logic       ch0_tick_raw;
  logic       ch1_tick_raw;
  logic       ch0_tick_ff;
  logic       ch1_tick_ff;
  logic       ch0_valid_ff;
  logic       ch1_valid_ff;
  scps_mode_t mode_ff;
  logic       full_rate_ff;
  logic       rate_chg;
  logic       ch0_restart;
  logic       ch1_restart;
  logic       nxt_ch0_tick;
  logic       nxt_ch0_valid;
  logic       nxt_ch1_tick;
  logic       nxt_ch1_valid;

  // Code legal when in range, 0110 barred at full rate
  function automatic logic code_ok(input logic [3:0] code, input logic full_rate);
    code_ok = (code >= SCPS_CODE_MIN) && (code <= SCPS_CODE_MAX)
              && !(full_rate && (code == SCPS_CODE_MIN));
  endfunction

  // Exponent relative to the divider input tick
  function automatic logic [3:0] code_exp(input logic [3:0] code, input logic [3:0] offs);
    code_exp = code - offs;
  endfunction

  assign wr.wr_en = wr_en_in;
  assign wr.addr  = addr_in;
  assign wr.wdata = wdata_in;
  assign mode     = scps_mode_t'(ch0_mode_sel_in);

  assign sel_write = wr.wr_en && (wr.addr == SCPS_SEL_ADDR);

  // Whole-byte load, no per-bit update path
  always_comb
  begin
    if (sel_write)
      nxt_serial_clock_prescale_select = wr.wdata;
    else
      nxt_serial_clock_prescale_select = serial_clock_prescale_select_ff;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      serial_clock_prescale_select_ff <= SCPS_SEL_RESET;
    else
      serial_clock_prescale_select_ff <= nxt_serial_clock_prescale_select;
  end

  // Half-rate prescale of the oscillator
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      half_ff <= 1'b0;
    else
      half_ff <= !half_ff;
  end

  // Mode change restarts divider 0 only, rate change restarts both dividers, no mixed-length period
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      mode_ff <= SCPS_MODE_SIO3;
    else
      mode_ff <= mode;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      full_rate_ff <= 1'b0;
    else
      full_rate_ff <= main_clk_full_rate_in;
  end

  assign src_tick = main_clk_full_rate_in ? 1'b1 : half_ff;

  assign ch0_code = serial_clock_prescale_select_ff[SCPS_CH0_LSB +: 4];
  assign ch1_code = serial_clock_prescale_select_ff[SCPS_CH1_LSB +: 4];

  always_comb
  begin
    case (mode)
      SCPS_MODE_BUS:  ch0_exp = code_exp(ch0_code, SCPS_BUS_EXP_OFFSET);
      SCPS_MODE_SIO2: ch0_exp = code_exp(ch0_code, SCPS_SIO_EXP_OFFSET);
      SCPS_MODE_SIO3: ch0_exp = code_exp(ch0_code, SCPS_SIO_EXP_OFFSET);
      default:        ch0_exp = code_exp(ch0_code, SCPS_SIO_EXP_OFFSET);
    endcase
  end

  assign ch1_exp = code_exp(ch1_code, SCPS_SIO_EXP_OFFSET);

  assign ch0_code_ok  = code_ok(ch0_code, main_clk_full_rate_in);
  assign ch1_code_ok  = code_ok(ch1_code, main_clk_full_rate_in);
  assign ch0_internal = ({ch0_clk_src_b1_in, ch0_clk_src_b0_in} == SCPS_SRC_INTERNAL);

  // Select-register write restarts both dividers
  assign rate_chg    = (main_clk_full_rate_in != full_rate_ff);
  assign ch0_restart = sel_write || rate_chg || (mode != mode_ff);
  assign ch1_restart = sel_write || rate_chg;

  scps_tick_gen u_ch0_div
  (
    .clk_sys_in  (clk_sys_in),
    .sys_rst_in  (sys_rst_in),
    .src_tick_in (src_tick),
    .exp_in      (ch0_exp),
    .restart_in  (ch0_restart),
    .tick_out    (ch0_tick_raw)
  );

  scps_tick_gen u_ch1_div
  (
    .clk_sys_in  (clk_sys_in),
    .sys_rst_in  (sys_rst_in),
    .src_tick_in (src_tick),
    .exp_in      (ch1_exp),
    .restart_in  (ch1_restart),
    .tick_out    (ch1_tick_raw)
  );

  // Strobe only with a legal code
  always_comb
  begin
    nxt_ch0_valid = ch0_code_ok && ch0_internal;
    nxt_ch0_tick  = ch0_tick_raw && nxt_ch0_valid;
  end

  always_comb
  begin
    nxt_ch1_valid = ch1_code_ok;
    nxt_ch1_tick  = ch1_tick_raw && nxt_ch1_valid;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      ch0_tick_ff <= 1'b0;
    else
      ch0_tick_ff <= nxt_ch0_tick;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      ch0_valid_ff <= 1'b0;
    else
      ch0_valid_ff <= nxt_ch0_valid;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      ch1_tick_ff <= 1'b0;
    else
      ch1_tick_ff <= nxt_ch1_tick;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in)
      ch1_valid_ff <= 1'b0;
    else
      ch1_valid_ff <= nxt_ch1_valid;
  end

  // Output bundle
  assign clk_o.ch0_tick  = ch0_tick_ff;
  assign clk_o.ch0_valid = ch0_valid_ff;
  assign clk_o.ch1_tick  = ch1_tick_ff;
  assign clk_o.ch1_valid = ch1_valid_ff;

  assign rdata_out     = serial_clock_prescale_select_ff;
  assign ch0_tick_out  = clk_o.ch0_tick;
  assign ch0_valid_out = clk_o.ch0_valid;
  assign ch1_tick_out  = clk_o.ch1_tick;
  assign ch1_valid_out = clk_o.ch1_valid;

endmodule // scps_top

//--- sim/scps_assertions.sv
`timescale 1ns/100ps
module scps_assertions
  import scps_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        sys_rst_in,
  input wire logic        wr_en_in,
  input wire logic [15:0] addr_in,
  input wire logic [7:0]  wdata_in,
  input wire logic        main_clk_full_rate_in,
  input wire logic [1:0]  ch0_mode_sel_in,
  input wire logic        ch0_clk_src_b1_in,
  input wire logic        ch0_clk_src_b0_in,
  input wire logic [7:0]  rdata_out,
  input wire logic        ch0_tick_out,
  input wire logic        ch0_valid_out,
  input wire logic        ch1_tick_out,
  input wire logic        ch1_valid_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  wire logic       f = main_clk_full_rate_in;
  wire logic [3:0] c0 = rdata_out[3:0];
  wire logic [3:0] c1 = rdata_out[7:4];
  wire logic ok0 = c0 >= 4'h6 && c0 <= 4'hD && !(f && c0 == 4'h6);
  wire logic ok1 = c1 >= 4'h6 && c1 <= 4'hD && !(f && c1 == 4'h6);
  wire logic src = ch0_clk_src_b1_in && ch0_clk_src_b0_in;
  a_reset_value: assert property (disable iff (1'b0) sys_rst_in |=> rdata_out == 8'h88)
    else $error("bad reset value");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst_in |=>
    !ch0_tick_out && !ch1_tick_out && !ch0_valid_out && !ch1_valid_out) else $error("not quiet");
  a_write_load: assert property (wr_en_in && addr_in == 16'hFF43
    |=> rdata_out == $past(wdata_in)) else $error("write lost");
  a_write_ignore: assert property (wr_en_in && addr_in != 16'hFF43 |=> $stable(rdata_out))
    else $error("stray write");
  a_ch0_valid: assert property (!$past(sys_rst_in) && $stable(rdata_out) && $stable(f) &&
    $stable(src) |-> ch0_valid_out == (ok0 && src)) else $error("ch0 valid");
  a_ch1_valid: assert property (!$past(sys_rst_in) && $stable(rdata_out) && $stable(f)
    |-> ch1_valid_out == ok1) else $error("ch1 valid");
  a_ch1_tick_gate: assert property (ch1_tick_out |-> ch1_valid_out)
    else $error("ch1 tick");
  a_ch0_tick_gate: assert property (ch0_tick_out |-> ch0_valid_out)
    else $error("ch0 tick");
  a_ch1_min_gap: assert property (ch1_tick_out && c1 == 4'h7 && f && $stable(rdata_out)
    |-> !$past(ch1_tick_out) && !$past(ch1_tick_out, 2) && !$past(ch1_tick_out, 3))
    else $error("ch1 gap");
endmodule // scps_assertions
bind scps_top scps_assertions u_chk (.*);

//--- sim/scps_shift_model.sv
`timescale 1ns/100ps
module scps_shift_model
(
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clr_in,
  input  wire logic        tick_in,
  output logic      [15:0] per_out
);
  logic [15:0] cnt_ff;
  // Shifts on the strobe only; keeps the spacing of the last two
  always_ff @(posedge clk_sys_in)
  begin
    if (sys_rst_in || clr_in)
    begin
      cnt_ff <= 16'h0000;
      per_out <= 16'h0000;
    end
    else
    begin
      if (tick_in)
        cnt_ff <= 16'h0001;
      else if (cnt_ff != 16'h0000)
        cnt_ff <= cnt_ff + 16'h0001;
      if (tick_in && cnt_ff != 16'h0000)
        per_out <= cnt_ff;
    end
  end
endmodule // scps_shift_model

//--- sim/serial_clock_prescale_select_tb_top.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin n_mismatch++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module serial_clock_prescale_select_tb_top;
  import scps_pkg::*;
  logic        clk_sys_in, sys_rst_in, wr_en_in, main_clk_full_rate_in;
  logic        ch0_clk_src_b1_in, ch0_clk_src_b0_in, ch0_tick_out, ch0_valid_out;
  logic        ch1_tick_out, ch1_valid_out;
  logic [1:0]  ch0_mode_sel_in;
  logic [15:0] addr_in, per0, per1;
  logic [7:0]  wdata_in, rdata_out, reg_v, d;
  logic [41:0] q[$];
  logic [41:0] e;
  int          n_mismatch, n_tests;
  event        ev;
  scps_top u_dut (.*);
  scps_shift_model u_m0 (.clk_sys_in, .sys_rst_in, .clr_in(wr_en_in), .tick_in(ch0_tick_out),
    .per_out(per0));
  scps_shift_model u_m1 (.clk_sys_in, .sys_rst_in, .clr_in(wr_en_in), .tick_in(ch1_tick_out),
    .per_out(per1));
  function automatic logic [15:0] per(logic [3:0] c, logic b, logic s);
    logic f;
    f = main_clk_full_rate_in;
    if (!s || c < 4'h6 || c > 4'hD || (f && c == 4'h6))
      return 16'h0000;
    return 16'h0001 << (c - (b ? 4'h1 : 4'h5) + {3'h0, !f});
  endfunction
  task automatic wr(logic [15:0] a, logic [7:0] v);
    @(negedge clk_sys_in);
    wr_en_in = 1'b1;
    addr_in = a;
    wdata_in = v;
    if (a == 16'hFF43)
      reg_v = v;
    @(negedge clk_sys_in);
    wr_en_in = 1'b0;
  endtask
  task automatic meas();
    logic [15:0] p0, p1;
    p0 = per(reg_v[3:0], ch0_mode_sel_in == 2'b10, ch0_clk_src_b1_in && ch0_clk_src_b0_in);
    p1 = per(reg_v[7:4], 1'b0, 1'b1);
    q.push_back({reg_v, p0 != 0, p1 != 0, p0, p1});
    repeat (3 * (p0 > p1 ? p0 : p1) + 8) @(negedge clk_sys_in);
    -> ev;
  endtask
  task automatic rst();
    sys_rst_in = 1'b1;
    repeat (20) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    reg_v = 8'h88;
  endtask
  task automatic complete_run();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end
  initial
  begin
    #400000;
    n_mismatch++;
    complete_run();
  end
  initial forever
  begin
    @(ev);
    e = q.pop_front();
    `CHK("rdata", e[41:34], rdata_out)
    `CHK("ch0_valid", e[33], ch0_valid_out)
    `CHK("ch1_valid", e[32], ch1_valid_out)
    `CHK("ch0_period", e[31:16], per0)
    `CHK("ch1_period", e[15:0], per1)
  end
  initial
  begin
    {wr_en_in, addr_in, wdata_in, ch0_mode_sel_in} = '0;
    {main_clk_full_rate_in, ch0_clk_src_b1_in, ch0_clk_src_b0_in} = 3'h7;
    void'($urandom(72));
    rst();
    meas();
    for (int i = 0; i < 14; i++)
    begin
      {main_clk_full_rate_in, ch0_mode_sel_in} = 3'($urandom);
      {ch0_clk_src_b1_in, ch0_clk_src_b0_in} = (i % 4 == 3) ? 2'($urandom) : 2'h3;
      d = {4'(6 + $urandom % 8), 4'(6 + $urandom % (ch0_mode_sel_in == 2'b10 ? 4 : 8))};
      if (main_clk_full_rate_in)
        d = {d[7:4] | {3'h0, d[7:4] == 4'h6}, d[3:0] | {3'h0, d[3:0] == 4'h6}};
      if (i < 2)
        {main_clk_full_rate_in, d} = i ? 9'h166 : {main_clk_full_rate_in, 8'hF0};
      wr(16'hFF43, d);
      wr(16'hFF42, 8'($urandom));
      meas();
    end
    rst();
    meas();
    @(negedge clk_sys_in);
    complete_run();
  end
endmodule // serial_clock_prescale_select_tb_top
